// file: hdl/temp_conversion_config.v
/*
 Configuration registers and conversion scheduler of a temperature
 monitor. Assumes the serial protocol engine delivers register writes
 and reads as single-cycle strobes with a pointer, and that high-limit
 flags come from the comparator logic on the same clock.
*/
`timescale 1ns/1ps
`include "temp_conv_consts.vh"

// How it works
// - Config reads at 03h, writes at 09h, reset 00h
// - Suppress bit holds alarm pin inactive in alarm mode
// - Shutdown bit selects run or shutdown
// - Pin function bit picks alarm or trip
// - Range bit selects standard or extended range
// - Resolution register at 1Ah sets local only
// - Resolution codes give 12.5 to 100 ms
// - Resolution changes conversion duration and timing
// - Resolution register resets to 1Ch
// - Rate reads at 04h, writes 0Ah, reset 08h
// - Rate changes only idle gap between conversions
// - Rate codes 0-6 scale, 07h-0Fh eight per second
// - One-shot write in shutdown starts one conversion
// - One-shot data discarded, return to shutdown
// - Shutdown mid-conversion finishes that conversion first
// - Ideality adjust at 18h, signed, reset 00h
// - Effective factor 1.008*300 over 300 minus adjust
// - Running converts continuously at programmed rate
// - Trip mode asserts on either high flag
module temp_conversion_config #(
    parameter CONV_BASE_CYC = (`CLK_HZ / 1000) * (`CONV_BASE_US / 100) / 10,
    parameter RATE_FAST_CYC = (`CLK_HZ / 1000) * (`RATE_FAST_US / 100) / 10
) (
    input wire clk_sys,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_ptr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rd_valid,
    input wire local_over_flag,
    input wire remote_over_flag,
    input wire alarm_event,
    output reg alarm_pin_n,
    output reg busy,
    output reg conv_done,
    output reg extended_range,
    output reg [1:0] local_res,
    output reg [7:0] ideality_out,
    output reg [31:0] neff_scaled
);
    localparam S_IDLE = 2'd0;
    localparam S_CONV = 2'd1;
    localparam S_GAP = 2'd2;

    reg [7:0] cfg_r;
    reg [7:0] rate_r;
    reg [7:0] res_r;
    reg [7:0] ideality_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg one_shot_r;
    reg alarm_latch_r;
    reg tmr_load;
    reg [31:0] tmr_val;
    wire tmr_expired;
    reg [7:0] cfg_nxt;
    reg [7:0] rate_nxt;
    reg [7:0] res_nxt;
    reg [7:0] ideality_nxt;
    reg [7:0] rdata_nxt;
    reg one_shot_nxt;
    reg alarm_latch_nxt;
    reg alarm_pin_nxt;
    reg busy_nxt;
    reg done_nxt;

    wire shutdown = cfg_r[`CFG_SHUTDOWN_BIT];
    wire suppress = cfg_r[`CFG_SUPPRESS_BIT];
    wire pin_trip = cfg_r[`CFG_PINFUNC_BIT];
    wire wr_cfg = reg_wr && (reg_ptr == `PTR_CFG_WR);
    wire wr_one_shot = reg_wr && (reg_ptr == `PTR_ONE_SHOT);
    // A one-shot only counts while shut down; a running device ignores it
    wire start_req = !shutdown || one_shot_r || (wr_one_shot && shutdown);

    // Conversion length doubles per extra resolution bit
    function [31:0] conv_cycles;
        input [1:0] res;
        begin
            conv_cycles = CONV_BASE_CYC << res;
        end
    endfunction

    // Whole period per rate code; codes above 7 share the fastest rate
    function [31:0] period_cycles;
        input [7:0] code;
        reg [2:0] sh;
        begin
            sh = (code >= `RATE_MAX_CODE) ? 3'd0 : (3'd7 - code[2:0]);
            period_cycles = RATE_FAST_CYC << sh;
        end
    endfunction

    // Gap fills the period after the conversion; never below one cycle
    function [31:0] gap_cycles;
        input [7:0] code;
        input [1:0] res;
        reg [31:0] p;
        reg [31:0] c;
        begin
            p = period_cycles(code);
            c = conv_cycles(res);
            gap_cycles = (p > c) ? (p - c) : 32'd1;
        end
    endfunction

    // Divisor runs from 173 to 428 over the signed range,
    // so it never reaches zero
    function [31:0] neff_calc;
        input [7:0] adj;
        reg [31:0] den;
        begin
            den = 32'd`NEFF_BASE - {{24{adj[7]}}, adj};
            neff_calc = (32'd`NEFF_NUM * 32'd100) / den;
        end
    endfunction

    // One timer serves both phases, as they never overlap
    conv_timer #(
        .WIDTH(32)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_expired)
    );

    // Write decode; config reserved bits are masked so they always read zero
    always @*
    begin
        cfg_nxt = cfg_r;
        rate_nxt = rate_r;
        res_nxt = res_r;
        ideality_nxt = ideality_r;
        if (reg_wr)
        begin
            case (reg_ptr)
                `PTR_CFG_WR:
                    cfg_nxt = reg_wdata & `CFG_WR_MASK;
                `PTR_RATE_WR:
                    rate_nxt = reg_wdata;
                `PTR_RES:
                    // Only the local bits are stored
                    res_nxt = `RES_FIXED | {6'd0, reg_wdata[1:0]};
                `PTR_IDEALITY:
                    ideality_nxt = reg_wdata;
                default:
                    ; // One-shot data is not stored
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r <= `CFG_RESET;
            rate_r <= `RATE_RESET;
            res_r <= `RES_RESET;
            ideality_r <= `IDEALITY_RESET;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            rate_r <= rate_nxt;
            res_r <= res_nxt;
            ideality_r <= ideality_nxt;
        end
    end

    // Unmapped and write-only pointers read as zero
    always @*
    begin
        rdata_nxt = reg_rdata;
        if (reg_rd)
        begin
            case (reg_ptr)
                `PTR_CFG_RD: rdata_nxt = cfg_r;
                `PTR_RATE_RD: rdata_nxt = rate_r;
                `PTR_RES: rdata_nxt = res_r;
                `PTR_IDEALITY: rdata_nxt = ideality_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rdata <= rdata_nxt;
            reg_rd_valid <= reg_rd;
        end
    end

    // Scheduler: conversions always run to their end
    always @*
    begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_val = 32'd0;
        case (state_r)
            S_IDLE:
            begin
                if (start_req)
                begin
                    state_nxt = S_CONV;
                    tmr_load = 1'b1;
                    tmr_val = conv_cycles(res_r[1:0]);
                end
            end
            S_CONV:
            begin
                if (tmr_expired)
                begin
                    if (shutdown)
                    begin
                        state_nxt = S_IDLE;
                    end
                    else
                    begin
                        state_nxt = S_GAP;
                        tmr_load = 1'b1;
                        tmr_val = gap_cycles(rate_r, res_r[1:0]);
                    end
                end
            end
            S_GAP:
            begin
                if (shutdown)
                begin
                    // Gap is dropped at once; only conversions finish
                    state_nxt = S_IDLE;
                end
                else if (tmr_expired)
                begin
                    state_nxt = S_CONV;
                    tmr_load = 1'b1;
                    tmr_val = conv_cycles(res_r[1:0]);
                end
            end
            default:
                state_nxt = S_IDLE;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= S_IDLE;
            one_shot_r <= 1'b0;
            busy <= 1'b0;
            conv_done <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            one_shot_r <= one_shot_nxt;
            busy <= busy_nxt;
            conv_done <= done_nxt;
        end
    end

    // Pending one-shot is dropped when the conversion it asked for starts
    always @*
    begin
        one_shot_nxt = one_shot_r;
        busy_nxt = (state_nxt == S_CONV);
        done_nxt = (state_r == S_CONV) && tmr_expired;
        // One-shot during a conversion in shutdown is kept for later
        if (state_r == S_IDLE && state_nxt == S_CONV)
            one_shot_nxt = 1'b0;
        else if (wr_one_shot && shutdown)
            one_shot_nxt = 1'b1;
    end

    // Alarm pin: trip mode follows flags, ignores suppress
    // Latch is kept in alarm mode; trip mode clears it when no event comes
    always @*
    begin
        alarm_latch_nxt = alarm_latch_r;
        if (alarm_event)
            alarm_latch_nxt = 1'b1;
        else if (pin_trip)
            alarm_latch_nxt = 1'b0;
        if (pin_trip)
            alarm_pin_nxt = !(local_over_flag || remote_over_flag);
        else
            alarm_pin_nxt = !((alarm_latch_r || alarm_event) &&
                !suppress);
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_latch_r <= 1'b0;
            alarm_pin_n <= 1'b1;
        end
        else
        begin
            alarm_latch_r <= alarm_latch_nxt;
            alarm_pin_n <= alarm_pin_nxt;
        end
    end

    // Effective ideality scaled by 1e5; adjust is signed
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extended_range <= 1'b0;
            local_res <= 2'b00;
            ideality_out <= 8'h00;
            neff_scaled <= 32'd100800;
        end
        else
        begin
            extended_range <= cfg_r[`CFG_RANGE_BIT];
            local_res <= res_r[1:0];
            ideality_out <= ideality_r;
            neff_scaled <= neff_calc(ideality_r);
        end
    end
endmodule

// file: hdl/temp_conv_consts.vh
/*
 Pointer addresses, field positions, reset values and timing figures
 for the conversion configuration block. Assumes inclusion by bare name.
*/
`ifndef TEMP_CONV_CONSTS_VH
`define TEMP_CONV_CONSTS_VH

`define PTR_CFG_RD 8'h03
`define PTR_CFG_WR 8'h09
`define PTR_RATE_RD 8'h04
`define PTR_RATE_WR 8'h0A
`define PTR_ONE_SHOT 8'h0F
`define PTR_IDEALITY 8'h18
`define PTR_RES 8'h1A

`define CFG_RESET 8'h00
`define CFG_WR_MASK 8'hE4
`define CFG_SUPPRESS_BIT 7
`define CFG_SHUTDOWN_BIT 6
`define CFG_PINFUNC_BIT 5
`define CFG_RANGE_BIT 2

`define RATE_RESET 8'h08
`define RATE_MAX_CODE 8'h07
`define RES_RESET 8'h1C
`define RES_FIXED 8'h1C
`define IDEALITY_RESET 8'h00

`define CLK_HZ 40000000
// Conversion time of the 9-bit setting, in microseconds
`define CONV_BASE_US 12500
// Period of 8 conversions per second, in microseconds
`define RATE_FAST_US 125000
`define NEFF_NUM 302400
`define NEFF_BASE 300

`endif

// file: hdl/conv_timer.v
/*
 Down-counter that times one conversion or one idle gap; expired is
 high in the last of load_val cycles, and a load of zero never expires.
 Assumes load is a single-cycle pulse on clk_sys.
*/
`timescale 1ns/1ps
module conv_timer #(
    parameter WIDTH = 32
) (
    input wire clk_sys,
    input wire rst_n,
    input wire load,
    input wire [WIDTH-1:0] load_val,
    output reg expired
);
    reg [WIDTH-1:0] count_r;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end
        else if (load)
        begin
            count_r <= load_val;
            expired <= (load_val == {{(WIDTH-1){1'b0}}, 1'b1});
        end
        else if (count_r != {WIDTH{1'b0}})
        begin
            count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
            // Flagged one count early so the phase lasts exactly load_val
            expired <= (count_r == {{(WIDTH-2){1'b0}}, 2'b10});
        end
        else
        begin
            expired <= 1'b0;
        end
    end
endmodule

// file: verif/conv_cfg_props.sv
/* Port checker for temp_conversion_config.
 Assumes it is bound to that block. */
`timescale 1ns/1ps
`include "temp_conv_consts.vh"
module conv_cfg_props #(
    parameter CONV_BASE_CYC = 20
) (
    input wire clk_sys,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_ptr,
    input wire [7:0] reg_wdata,
    input wire reg_rd_valid,
    input wire local_over_flag,
    input wire remote_over_flag,
    input wire alarm_pin_n,
    input wire busy,
    input wire conv_done,
    input wire extended_range,
    input wire [1:0] local_res,
    input wire [7:0] ideality_out,
    input wire [31:0] neff_scaled
);
    // Config shadow: the real register is internal
    logic [7:0] cfg_r;
    logic [31:0] run_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
        begin
            cfg_r <= `CFG_RESET;
            run_r <= 32'h0000_0000;
        end
        else
        begin
            if (reg_wr && reg_ptr == `PTR_CFG_WR)
                cfg_r <= reg_wdata & `CFG_WR_MASK;
            run_r <= busy ? run_r + 32'h0000_0001 : 32'h0000_0000;
        end
    sequence s_end;
        $fell(busy);
    endsequence
    sequence s_adj0;
        (ideality_out == 8'h00) [*3];
    endsequence
    a_rd_answer: assert property (reg_rd |=> reg_rd_valid)
        else $error("read not answered");
    a_rd_cause: assert property (reg_rd_valid |-> $past(reg_rd))
        else $error("stray read answer");
    a_end_done: assert property (s_end |-> conv_done)
        else $error("no done pulse");
    a_conv_len: assert property (s_end |->
        run_r == (CONV_BASE_CYC << local_res)) else $error("conv length");
    a_trip_pin: assert property ($past(cfg_r[5]) |->
        alarm_pin_n == !$past(local_over_flag | remote_over_flag))
        else $error("trip pin");
    a_mask_pin: assert property ($past(cfg_r[7] & ~cfg_r[5]) |->
        alarm_pin_n) else $error("masked pin low");
    a_range_out: assert property (extended_range == $past(cfg_r[2]))
        else $error("range output");
    a_neff_dflt: assert property (s_adj0 |->
        neff_scaled == 32'h0001_89C0) else $error("default factor");
endmodule
bind temp_conversion_config conv_cfg_props #(
    .CONV_BASE_CYC(CONV_BASE_CYC)
) i_conv_cfg_props (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_ptr,
    .reg_wdata, .reg_rd_valid, .local_over_flag, .remote_over_flag,
    .alarm_pin_n, .busy, .conv_done, .extended_range, .local_res,
    .ideality_out, .neff_scaled);

// file: verif/reg_host.sv
/* Register host model: one-cycle strobes.
 Assumes the block samples on rising clk_sys. */
`timescale 1ns/1ps
module reg_host (
    input wire clk_sys,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_ptr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid
);
    // Released lines go inverted so stale data cannot pass
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_ptr = p;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_ptr = ~p;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] p, output logic [8:0] dv);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_ptr = p;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_ptr = ~p;
        dv = {reg_rdata, reg_rd_valid};
    endtask
endmodule

// file: verif/tb_temp_conversion_config.sv
/* Bench for temp_conversion_config.
 Assumes reg_host drives the register strobes. */
`timescale 1ns/1ps
module tb_temp_conversion_config;
    localparam int CB = 20;
    localparam int RF = 400;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic local_over_flag = 1'b0;
    logic remote_over_flag = 1'b0;
    logic alarm_event = 1'b0;
    wire reg_wr, reg_rd, reg_rd_valid, alarm_pin_n, busy, conv_done;
    wire extended_range;
    wire [7:0] reg_ptr, reg_wdata, reg_rdata, ideality_out;
    wire [1:0] local_res;
    wire [31:0] neff_scaled;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] rp[5] = '{8'h03, 8'h04, 8'h1A, 8'h18, 8'h55};
    logic [7:0] rv[5] = '{8'h00, 8'h08, 8'h1C, 8'h00, 8'h00};
    logic [7:0] rc[4] = '{8'h0F, 8'h07, 8'h06, 8'h04};
    // Rows: config, local flag, remote flag, event, pin
    logic [11:0] at[6] = '{12'h608, 12'h604, 12'h601, 12'hE08,
        12'hC03, 12'h400};
    always #12.5 clk_sys = ~clk_sys;
    reg_host i_reg_host (.clk_sys, .reg_wr, .reg_rd, .reg_ptr,
        .reg_wdata, .reg_rdata, .reg_rd_valid);
    temp_conversion_config #(.CONV_BASE_CYC(CB), .RATE_FAST_CYC(RF))
        i_temp_conversion_config (.clk_sys, .rst_n, .reg_wr, .reg_rd,
        .reg_ptr, .reg_wdata, .reg_rdata, .reg_rd_valid, .local_over_flag,
        .remote_over_flag, .alarm_event, .alarm_pin_n, .busy, .conv_done,
        .extended_range, .local_res, .ideality_out, .neff_scaled);
    task automatic stop_test(input bit hung);
        if (hung)
            err_count++;
        $display("Checks %0d, errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] p, d);
        i_reg_host.wr(p, d);
    endtask
    task automatic rchk(input logic [7:0] p, e);
        logic [8:0] dv;
        i_reg_host.rd(p, dv);
        chk("rdata_valid", {23'h0, e, 1'b1}, {23'h0, dv});
    endtask
    // First period after a rate write may straddle it, so skip it
    task automatic per(input int e);
        int t;
        repeat (2) @(posedge conv_done);
        t = cyc;
        @(posedge conv_done);
        chk("period", e, cyc - t);
    endtask
    always @(posedge clk_sys)
        if (++cyc == 40000)
            stop_test(1'b1);
    initial
    begin
        int n;
        int sa;
        wt(20);
        rst_n = 1'b1;
        wt(2);
        chk("busy", 1, busy);
        for (int i = 0; i < 5; i++)
            rchk(rp[i], rv[i]);
        chk("neff", 32'h0001_89C0, neff_scaled);
        wr(8'h04, 8'h33);
        rchk(8'h04, 8'h08);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h0A, rc[i]);
            per(rc[i] >= 8'h07 ? RF : RF << (8'h07 - rc[i]));
        end
        @(posedge busy);
        wr(8'h09, 8'h44);
        chk("busy", 1, busy);
        wt(500);
        chk("busy", 0, busy);
        rchk(8'h03, 8'h44);
        chk("range", 1, extended_range);
        wt(8000);
        wr(8'h1A, 8'h1E);
        rchk(8'h1A, 8'h1E);
        chk("res", 2, local_res);
        wr(8'h0F, 8'hA5);
        n = 0;
        repeat (300)
        begin
            n += (busy === 1'b1);
            wt(1);
        end
        chk("conv", 4 * CB, n);
        rchk(8'h0F, 8'h00);
        wr(8'h1A, 8'hFF);
        rchk(8'h1A, 8'h1F);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h09, at[i][11:4]);
            {local_over_flag, remote_over_flag, alarm_event} = at[i][3:1];
            wt(1);
            alarm_event = 1'b0;
            wt(3);
            chk("pin", at[i][0], alarm_pin_n);
        end
        sa = $signed(8'hC4);
        wr(8'h18, 8'hC4);
        rchk(8'h18, 8'hC4);
        wt(3);
        chk("adj", 8'hC4, ideality_out);
        chk("neff", 32'h01CD_6D00 / (32'sh0000_012C - sa), neff_scaled);
        stop_test(1'b0);
    end
endmodule
